/* File: core/scc_regs.svh */
/*
 * Timing constants of the SDRAM command-state checker.
 * Assumes a 125 MHz sys_clk_i; times are in ns and rounded up to cycles.
 */
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

`define SCC_CLK_MHZ 125
`define SCC_CYC(ns) ((((ns) * `SCC_CLK_MHZ) + 999) / 1000)

`define SCC_ROW_TO_COLUMN_DELAY_NS 30
`define SCC_PRECHARGE_PERIOD_NS 30
`define SCC_WRITE_RECOVERY_TIME_NS 48
`define SCC_REFRESH_PERIOD_NS 80
`define SCC_POWER_DOWN_EXIT_TIME_NS 16
`define SCC_SELF_REFRESH_EXIT_NS 120
`define SCC_DEEP_PD_EXIT_NS 200
`define SCC_MODE_SET_CYCLES 2

`define SCC_ROW_TO_COLUMN_CYC `SCC_CYC(`SCC_ROW_TO_COLUMN_DELAY_NS)
`define SCC_PRECHARGE_CYC `SCC_CYC(`SCC_PRECHARGE_PERIOD_NS)
`define SCC_WRITE_RECOVERY_CYC `SCC_CYC(`SCC_WRITE_RECOVERY_TIME_NS)
`define SCC_REFRESH_CYC `SCC_CYC(`SCC_REFRESH_PERIOD_NS)
`define SCC_POWER_DOWN_EXIT_CYC `SCC_CYC(`SCC_POWER_DOWN_EXIT_TIME_NS)
`define SCC_SELF_REFRESH_EXIT_CYC `SCC_CYC(`SCC_SELF_REFRESH_EXIT_NS)
`define SCC_DEEP_PD_EXIT_CYC `SCC_CYC(`SCC_DEEP_PD_EXIT_NS)

`define SCC_AUTO_PRECHARGE_BIT 10
`define SCC_NUM_BANKS 4

`endif

/* File: core/scc_pkg.sv */
/*
 * Types of the SDRAM command-state checker.
 * Assumes nothing beyond the timing header used by the core.
 */
`default_nettype none
package scc_pkg;

  typedef enum logic [3:0] {
    SCC_CMD_DESELECT, SCC_CMD_NOP, SCC_CMD_BURST_STOP, SCC_CMD_READ, SCC_CMD_WRITE,
    SCC_CMD_ACTIVE, SCC_CMD_PRECHARGE, SCC_CMD_REFRESH, SCC_CMD_MODE_REGISTER_SET
  } scc_cmd_t;

  typedef enum logic [2:0] {
    SCC_BANK_IDLE, SCC_BANK_ACTIVATING, SCC_BANK_ACTIVE, SCC_BANK_PRECHARGING,
    SCC_BANK_WRITE_RECOVERING, SCC_BANK_WRITE_AUTO_CLOSE
  } scc_bank_t;

  typedef enum logic [2:0] {
    SCC_PWR_NORMAL, SCC_PWR_REFRESHING, SCC_PWR_MODE_SETTING, SCC_PWR_POWER_DOWN,
    SCC_PWR_PD_EXITING, SCC_PWR_SELF_REFRESH, SCC_PWR_SR_EXITING, SCC_PWR_DEEP_PD
  } scc_pwr_t;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [13:0] addr;
  } scc_pins_t;

  typedef struct packed {
    scc_pwr_t pwr;
    scc_bank_t [3:0] bank;
    logic all_idle;
    logic accepted;
    logic illegal;
  } scc_status_t;

endpackage
`default_nettype wire

/* File: core/scc_checker.sv */
/*
 * Command-acceptance and power-state tracker of a low-power DDR SDRAM.
 * Assumes command pins synchronous to sys_clk_i, sampled on its rising edge.
 */
// Behaviour
// - Command table applies only when clock enable was high last and this cycle.
// - Illegal commands are flagged with a one-cycle violation pulse.
// - Precharge to an idle or precharging bank is a no-operation for it.
// - Rising clock enable in self-refresh starts the exit time at once; only deselect or nop until it ends.
// - Falling clock enable with burst-stop encoding and banks idle enters deep power-down.
// - Power-down holds while clock enable stays low, whatever the commands.
// - Rising clock enable leaves power-down; idle only after the exit time.
// - Banks idle, clock enable steady high: normal command decoding.
// - Banks idle, clock enable low last cycle: power-down handling, no decoding.
`timescale 1ns/1ps
`default_nettype none
`include "scc_regs.svh"

module scc_checker
  import scc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Command pins from the memory controller
  input wire scc_pins_t pins_i,
  // Tracked state
  output scc_status_t status_o
);

  function automatic scc_cmd_t decode(input scc_pins_t p);
    if (p.cs_n) begin
      return SCC_CMD_DESELECT;
    end
    unique case ({p.ras_n, p.cas_n, p.we_n})
      3'h7: return SCC_CMD_NOP;
      3'h6: return SCC_CMD_BURST_STOP;
      3'h5: return SCC_CMD_READ;
      3'h4: return SCC_CMD_WRITE;
      3'h3: return SCC_CMD_ACTIVE;
      3'h2: return SCC_CMD_PRECHARGE;
      3'h1: return SCC_CMD_REFRESH;
      default: return SCC_CMD_MODE_REGISTER_SET;
    endcase
  endfunction

  function automatic logic is_quiet(input scc_cmd_t c);
    return (c == SCC_CMD_DESELECT) || (c == SCC_CMD_NOP);
  endfunction

  scc_bank_t [3:0] bank;
  scc_bank_t [3:0] next_bank;
  logic [3:0][7:0] bank_cnt;
  logic [3:0][7:0] next_bank_cnt;
  scc_pwr_t pwr;
  scc_pwr_t next_pwr;
  logic [7:0] pwr_cnt;
  logic [7:0] next_pwr_cnt;
  logic cke_prev;
  logic next_cke_prev;
  scc_status_t status;
  scc_status_t next_status;

  always_comb begin
    scc_cmd_t cmd;
    logic banks_idle;
    logic steady;
    logic bad;
    logic hit;
    logic auto_close;
    cmd = decode(pins_i);
    banks_idle = 1'b1;
    steady = cke_prev && pins_i.cke;
    bad = 1'b0;
    hit = 1'b0;
    auto_close = pins_i.addr[`SCC_AUTO_PRECHARGE_BIT];
    next_bank = bank;
    next_bank_cnt = bank_cnt;
    next_pwr = pwr;
    next_pwr_cnt = pwr_cnt;
    next_cke_prev = pins_i.cke;
    for (int b = 0; b < `SCC_NUM_BANKS; b++) begin
      if (bank[b] != SCC_BANK_IDLE) begin
        banks_idle = 1'b0;
      end
    end
    // Timed bank states run down in every power state
    for (int b = 0; b < `SCC_NUM_BANKS; b++) begin
      if (bank[b] != SCC_BANK_IDLE && bank[b] != SCC_BANK_ACTIVE) begin
        if (bank_cnt[b] == 8'h00) begin
          unique case (bank[b])
            SCC_BANK_ACTIVATING: next_bank[b] = SCC_BANK_ACTIVE;
            SCC_BANK_PRECHARGING: next_bank[b] = SCC_BANK_IDLE;
            SCC_BANK_WRITE_RECOVERING: next_bank[b] = SCC_BANK_ACTIVE;
            SCC_BANK_WRITE_AUTO_CLOSE: begin
              next_bank[b] = SCC_BANK_PRECHARGING;
              next_bank_cnt[b] = 8'(`SCC_PRECHARGE_CYC - 1);
            end
            default: next_bank[b] = bank[b];
          endcase
        end else begin
          next_bank_cnt[b] = bank_cnt[b] - 8'h01;
        end
      end
    end
    if (pwr_cnt != 8'h00) begin
      next_pwr_cnt = pwr_cnt - 8'h01;
    end
    unique case (pwr)
      SCC_PWR_NORMAL: begin
        if (steady) begin
          // Per-bank table decode
          for (int b = 0; b < `SCC_NUM_BANKS; b++) begin
            hit = (pins_i.ba == 2'(b)) ||
                  (cmd == SCC_CMD_PRECHARGE && auto_close);
            if (hit) begin
              unique case (cmd)
                SCC_CMD_READ: begin
                  if (bank[b] == SCC_BANK_ACTIVE) begin
                    if (auto_close) begin
                      next_bank[b] = SCC_BANK_PRECHARGING;
                      next_bank_cnt[b] = 8'(`SCC_PRECHARGE_CYC - 1);
                    end
                  end else begin
                    bad = 1'b1;
                  end
                end
                SCC_CMD_WRITE: begin
                  if (bank[b] == SCC_BANK_ACTIVE || bank[b] == SCC_BANK_WRITE_RECOVERING) begin
                    next_bank[b] = auto_close ? SCC_BANK_WRITE_AUTO_CLOSE : SCC_BANK_WRITE_RECOVERING;
                    next_bank_cnt[b] = 8'(`SCC_WRITE_RECOVERY_CYC - 1);
                  end else begin
                    bad = 1'b1;
                  end
                end
                SCC_CMD_ACTIVE: begin
                  if (bank[b] == SCC_BANK_IDLE) begin
                    next_bank[b] = SCC_BANK_ACTIVATING;
                    next_bank_cnt[b] = 8'(`SCC_ROW_TO_COLUMN_CYC - 1);
                  end else begin
                    bad = 1'b1;
                  end
                end
                SCC_CMD_PRECHARGE: begin
                  if (bank[b] == SCC_BANK_ACTIVE) begin
                    next_bank[b] = SCC_BANK_PRECHARGING;
                    next_bank_cnt[b] = 8'(`SCC_PRECHARGE_CYC - 1);
                  end else if (bank[b] != SCC_BANK_IDLE && bank[b] != SCC_BANK_PRECHARGING) begin
                    bad = 1'b1;
                  end
                end
                SCC_CMD_BURST_STOP: begin
                  if (bank[b] != SCC_BANK_ACTIVE) begin
                    bad = 1'b1;
                  end
                end
                default: begin
                end
              endcase
            end
          end
          if (cmd == SCC_CMD_REFRESH || cmd == SCC_CMD_MODE_REGISTER_SET) begin
            if (!banks_idle) begin
              bad = 1'b1;
            end else if (cmd == SCC_CMD_REFRESH) begin
              next_pwr = SCC_PWR_REFRESHING;
              next_pwr_cnt = 8'(`SCC_REFRESH_CYC - 1);
            end else begin
              next_pwr = SCC_PWR_MODE_SETTING;
              next_pwr_cnt = 8'(`SCC_MODE_SET_CYCLES - 1);
            end
          end
        end else if (cke_prev && !pins_i.cke) begin
          if (!banks_idle) begin
            bad = 1'b1;
          end else if (is_quiet(cmd)) begin
            next_pwr = SCC_PWR_POWER_DOWN;
          end else if (cmd == SCC_CMD_REFRESH) begin
            next_pwr = SCC_PWR_SELF_REFRESH;
          end else if (cmd == SCC_CMD_BURST_STOP) begin
            next_pwr = SCC_PWR_DEEP_PD;
          end else begin
            bad = 1'b1;
          end
        end else if (!cke_prev) begin
          // Low enable seen after reset behaves as power-down
          next_pwr = pins_i.cke ? SCC_PWR_PD_EXITING : SCC_PWR_POWER_DOWN;
          next_pwr_cnt = 8'(`SCC_POWER_DOWN_EXIT_CYC - 1);
        end
      end
      SCC_PWR_REFRESHING, SCC_PWR_MODE_SETTING, SCC_PWR_PD_EXITING, SCC_PWR_SR_EXITING: begin
        // Busy windows take only deselect or nop
        if (!is_quiet(cmd) || !pins_i.cke) begin
          bad = 1'b1;
        end
        if (pwr_cnt == 8'h00) begin
          next_pwr = SCC_PWR_NORMAL;
        end
      end
      SCC_PWR_POWER_DOWN: begin
        if (pins_i.cke) begin
          next_pwr = SCC_PWR_PD_EXITING;
          next_pwr_cnt = 8'(`SCC_POWER_DOWN_EXIT_CYC - 1);
        end
      end
      SCC_PWR_SELF_REFRESH: begin
        if (pins_i.cke) begin
          // Wake-up taken on the edge the enable is first seen high
          next_pwr = SCC_PWR_SR_EXITING;
          next_pwr_cnt = 8'(`SCC_SELF_REFRESH_EXIT_CYC - 1);
          if (!is_quiet(cmd)) begin
            bad = 1'b1;
          end
        end
      end
      SCC_PWR_DEEP_PD: begin
        if (pins_i.cke) begin
          next_pwr = SCC_PWR_PD_EXITING;
          next_pwr_cnt = 8'(`SCC_DEEP_PD_EXIT_CYC - 1);
        end
      end
      default: next_pwr = SCC_PWR_NORMAL;
    endcase
    next_status.pwr = next_pwr;
    next_status.bank = next_bank;
    next_status.all_idle = banks_idle;
    next_status.accepted = !bad && !is_quiet(cmd) && steady && pwr == SCC_PWR_NORMAL;
    next_status.illegal = bad;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bank <= '{default: SCC_BANK_IDLE};
      bank_cnt <= '0;
      pwr <= SCC_PWR_NORMAL;
      pwr_cnt <= 8'h00;
      cke_prev <= 1'b0;
      status <= '{pwr: SCC_PWR_NORMAL, bank: '{default: SCC_BANK_IDLE},
                  all_idle: 1'b1, accepted: 1'b0, illegal: 1'b0};
    end else begin
      bank <= next_bank;
      bank_cnt <= next_bank_cnt;
      pwr <= next_pwr;
      pwr_cnt <= next_pwr_cnt;
      cke_prev <= next_cke_prev;
      status <= next_status;
    end
  end

  assign status_o = status;

endmodule

`default_nettype wire

/* File: verification/scc_checker_chk.sv */
/* Assertions on the command and power state ports of scc_checker.
   Assumes pins_i changes only after rising edges of sys_clk_i. */
`timescale 1ns/1ps
`default_nettype none
`include "scc_regs.svh"
module scc_checker_chk
  import scc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire scc_pins_t pins_i,
  input wire scc_status_t status_o
);
  logic ckp;
  logic [3:0] c;
  logic idl;
  logic run;
  logic nf;
  scc_pwr_t pw;
  always_ff @(posedge sys_clk_i) begin
    ckp <= rst_n_i & pins_i.cke;
  end
  assign pw = status_o.pwr;
  assign c = {pins_i.cs_n, pins_i.ras_n, pins_i.cas_n, pins_i.we_n};
  assign idl = status_o.bank == {4{SCC_BANK_IDLE}};
  assign run = pw == SCC_PWR_NORMAL && ckp && pins_i.cke;
  assign nf = pw == SCC_PWR_NORMAL && idl && ckp && !pins_i.cke;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Activate of idle bank 0 and its opening window
  sequence s_act;
    run && c == 4'h3 && pins_i.ba == 2'h0 && status_o.bank[0] == SCC_BANK_IDLE;
  endsequence
  sequence s_open;
    (status_o.bank[0] == SCC_BANK_ACTIVATING) [*4] ##1 status_o.bank[0] == SCC_BANK_ACTIVE;
  endsequence
  a_act_open: assert property (s_act |=> s_open) else $error("bank open timing wrong");
  a_act_accept: assert property (s_act |=> status_o.accepted) else $error("legal activate not accepted");
  a_idle_flag: assert property (rst_n_i |=> status_o.all_idle == $past(idl))
    else $error("all idle flag wrong");
  a_act_busy: assert property (run && c == 4'h3 && status_o.bank[pins_i.ba] == SCC_BANK_ACTIVATING
    |=> status_o.illegal) else $error("activate while opening not flagged");
  a_ref_open: assert property (run && c == 4'h1 && !idl |=> status_o.illegal && pw == SCC_PWR_NORMAL)
    else $error("refresh with open bank not flagged");
  a_pre_nop: assert property (run && c == 4'h2 && !pins_i.addr[`SCC_AUTO_PRECHARGE_BIT]
    && status_o.bank[pins_i.ba] == SCC_BANK_IDLE |=> !status_o.illegal)
    else $error("precharge of idle bank flagged");
  a_pd_enter: assert property (nf && (pins_i.cs_n || c == 4'h7) |=> pw == SCC_PWR_POWER_DOWN)
    else $error("power-down not entered");
  a_sr_enter: assert property (nf && c == 4'h1 |=> pw == SCC_PWR_SELF_REFRESH) else $error("no self-refresh");
  a_deep_enter: assert property (nf && c == 4'h6 |=> pw == SCC_PWR_DEEP_PD) else $error("no deep power-down");
  a_low_hold: assert property ((pw == SCC_PWR_POWER_DOWN || pw == SCC_PWR_SELF_REFRESH)
    && !pins_i.cke |=> pw == $past(pw)) else $error("low power state left");
  a_pd_exit: assert property (pw == SCC_PWR_POWER_DOWN && pins_i.cke
    |=> (pw == SCC_PWR_PD_EXITING) [*2]) else $error("power-down exit wrong");
  a_sr_exit: assert property (pw == SCC_PWR_SELF_REFRESH && pins_i.cke
    |=> pw == SCC_PWR_SR_EXITING) else $error("self-refresh exit wrong");
endmodule
bind scc_checker scc_checker_chk scc_checker_chk_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .pins_i(pins_i), .status_o(status_o));
`default_nettype wire

/* File: verification/scc_ctl_model.sv */
/* Controller side pin driver for the checker bench.
   Assumes req_i is set just after rising edges of sys_clk_i. */
`timescale 1ns/1ps
`default_nettype none
module scc_ctl_model
  import scc_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Request from the bench
  input wire scc_pins_t req_i,
  // Command pins
  output wire scc_pins_t pins_o
);
  logic [13:0] junk = 14'h1a5;
  always_ff @(posedge sys_clk_i) begin
    junk <= ~junk + 14'h1;
  end
  // Address shows a moving pattern while deselected
  assign pins_o = req_i.cs_n ? {req_i[20:14], junk} : req_i;
endmodule
`default_nettype wire

/* File: verification/scc_checker_tb.sv */
/* Self-checking bench for scc_checker with queued expected notes.
   Assumes the timing header and package are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "scc_regs.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin mismatches++; $display("unexpected %s exp %h got %h", n, e, s); end end
module scc_checker_tb;
  import scc_pkg::*;
  typedef struct packed {
    int due;
    logic ill;
    scc_pwr_t pw;
    scc_bank_t b0;
  } scc_note_t;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  scc_pins_t req = 21'h170000;
  scc_pins_t pins;
  scc_status_t st;
  scc_note_t q[$];
  int ncyc = 0;
  int mismatches = 0;
  int compares = 0;
  int seed = 32'h2a0d6aff;
  logic [31:0] rnd;
  logic [3:0] ce [3] = '{4'h7, 4'h1, 4'h6};
  scc_pwr_t ps [3] = '{SCC_PWR_POWER_DOWN, SCC_PWR_SELF_REFRESH, SCC_PWR_DEEP_PD};
  scc_pwr_t xs [3] = '{SCC_PWR_PD_EXITING, SCC_PWR_SR_EXITING, SCC_PWR_PD_EXITING};
  int xw [3] = '{`SCC_POWER_DOWN_EXIT_CYC + 1, `SCC_SELF_REFRESH_EXIT_CYC + 1, `SCC_DEEP_PD_EXIT_CYC + 1};
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  scc_ctl_model scc_ctl_model_inst (.sys_clk_i(sys_clk_i), .req_i(req), .pins_o(pins));
  scc_checker scc_checker_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .pins_i(pins), .status_o(st));
  function automatic scc_pins_t enc(logic k, logic [3:0] cm, logic [1:0] b, logic a);
    return {k, cm, b, 3'h0, a, 10'h0};
  endfunction
  task automatic c(scc_pins_t p, logic il, scc_pwr_t pw, scc_bank_t b);
    @(posedge sys_clk_i);
    req <= p;
    q.push_back('{ncyc + 2, il, pw, b});
  endtask
  task automatic idle(int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      req <= enc(1'b1, 4'h7, 2'h0, 1'b0);
    end
  endtask
  task tend(string s);
    $display("test %s done", s);
  endtask
  task finish_test;
    $display("counts mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Result watcher
  always @(negedge sys_clk_i) begin
    ncyc++;
    if (q.size() > 0 && q[0].due == ncyc) begin
      `CHK("illegal", q[0].ill, st.illegal)
      `CHK("pwr", q[0].pw, st.pwr)
      `CHK("bank0", q[0].b0, st.bank[0])
      void'(q.pop_front());
    end
  end
  initial begin
    #16000;
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    `CHK("pwr", SCC_PWR_NORMAL, st.pwr)
    `CHK("all_idle", 1'b1, st.all_idle)
    `CHK("accepted", 1'b0, st.accepted)
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    tend("reset");
    idle(6);
    c(enc(1'b1, 4'h3, 2'h0, 1'b0), 1'b0, SCC_PWR_NORMAL, SCC_BANK_ACTIVATING);
    c(enc(1'b1, 4'h3, 2'h0, 1'b0), 1'b1, SCC_PWR_NORMAL, SCC_BANK_ACTIVATING);
    idle(4);
    c(enc(1'b1, 4'h1, 2'h0, 1'b0), 1'b1, SCC_PWR_NORMAL, SCC_BANK_ACTIVE);
    c(enc(1'b1, 4'h2, 2'h1, 1'b0), 1'b0, SCC_PWR_NORMAL, SCC_BANK_ACTIVE);
    c(enc(1'b1, 4'h4, 2'h0, 1'b0), 1'b0, SCC_PWR_NORMAL, SCC_BANK_WRITE_RECOVERING);
    c(enc(1'b1, 4'h5, 2'h0, 1'b0), 1'b1, SCC_PWR_NORMAL, SCC_BANK_WRITE_RECOVERING);
    idle(`SCC_WRITE_RECOVERY_CYC);
    c(enc(1'b1, 4'h2, 2'h3, 1'b1), 1'b0, SCC_PWR_NORMAL, SCC_BANK_PRECHARGING);
    idle(`SCC_PRECHARGE_CYC + 1);
    c(enc(1'b1, 4'h3, 2'h0, 1'b0), 1'b0, SCC_PWR_NORMAL, SCC_BANK_ACTIVATING);
    idle(4);
    c(enc(1'b1, 4'h4, 2'h0, 1'b1), 1'b0, SCC_PWR_NORMAL, SCC_BANK_WRITE_AUTO_CLOSE);
    c(enc(1'b1, 4'h5, 2'h0, 1'b0), 1'b1, SCC_PWR_NORMAL, SCC_BANK_WRITE_AUTO_CLOSE);
    idle(`SCC_WRITE_RECOVERY_CYC + `SCC_PRECHARGE_CYC - 1);
    c(enc(1'b1, 4'h0, 2'h0, 1'b0), 1'b0, SCC_PWR_MODE_SETTING, SCC_BANK_IDLE);
    idle(3);
    c(enc(1'b1, 4'h1, 2'h0, 1'b0), 1'b0, SCC_PWR_REFRESHING, SCC_BANK_IDLE);
    idle(`SCC_REFRESH_CYC + 1);
    tend("commands");
    for (int i = 0; i < 3; i++) begin
      rnd = $random(seed);
      c(enc(1'b0, ce[i], 2'h0, 1'b0), 1'b0, ps[i], SCC_BANK_IDLE);
      c(enc(1'b0, rnd[3:0], rnd[5:4], rnd[6]), 1'b0, ps[i], SCC_BANK_IDLE);
      c(enc(1'b1, 4'h7, 2'h0, 1'b0), 1'b0, xs[i], SCC_BANK_IDLE);
      idle(xw[i]);
    end
    idle(4);
    `CHK("queue", 0, q.size())
    tend("power");
    finish_test;
  end
endmodule
`default_nettype wire
